/* File: design/math_unit_consts.vh */
// Register offsets, field positions and constants of the math unit.
`ifndef MATH_UNIT_CONSTS_VH
`define MATH_UNIT_CONSTS_VH
// ==========================================================
// Register offsets.
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_SRC 8'h08
`define REG_CNT 8'h0C
`define REG_DST 8'h10
`define REG_MEM_ADDR 8'h14
`define REG_MEM_DATA 8'h18
`define REG_IRQ_STAT 8'h1C
`define REG_IRQ_MASK 8'h20
// ==========================================================
// Command and operand fields.
`define CMD_EXEC_BIT 4
`define OP_AVG 2'h0
`define OP_SUM 2'h1
`define OP_MIN 2'h2
`define IND_BIT 15
`define SUM_SIGNED_BIT 15
`define SUM_BIN_BIT 14
`define SUM_BYTE_BIT 13
`define MIN_SIGNED_BIT 14
`define HIST_FULL_BIT 15
// ==========================================================
// Limits and counts.
`define AVG_N_SAT_BCD 16'h0065
`define AVG_N_SAT 7'h40
`define MEM_WORDS 14'h0200
`define MEM_AW 9
`define DIV_STEPS 5'h17
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`endif

/* File: design/word_memory.v */
// Single-port data memory with registered read data.
`timescale 1ns/100ps
`default_nettype none
module word_memory (
   input wire clk_sys,
   input wire we,
   input wire [8:0] addr,
   input wire [15:0] wdata,
   output reg [15:0] rdata
);
   reg [15:0] mem_q [0:511];

   // ==========================================================
   // Storage.
   always @(posedge clk_sys) begin
      if (we) begin
         mem_q[addr] <= wdata;
      end
      rdata <= mem_q[addr];
   end
endmodule // word_memory
`default_nettype wire

/* File: design/average_and_sum_math_unit.v */
// Running average, range sum and minimum flag execution unit.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "math_unit_consts.vh"
module average_and_sum_math_unit (
   input wire clk_sys,
   input wire rst_n,
   input wire [7:0] addr,
   input wire [15:0] wr_data,
   input wire wr_en,
   input wire rd_en,
   output reg [15:0] rd_data,
   output wire irq,
   output wire busy,
   output reg error_flag,
   output reg equality_flag
);
   localparam ST_IDLE = 13'h0001;
   localparam ST_PS = 13'h0002;
   localparam ST_PD = 13'h0004;
   localparam ST_CHK = 13'h0008;
   localparam ST_A1 = 13'h0010;
   localparam ST_A2 = 13'h0020;
   localparam ST_A3 = 13'h0040;
   localparam ST_A4 = 13'h0080;
   localparam ST_RUN = 13'h0100;
   localparam ST_DIV = 13'h0200;
   localparam ST_WR1 = 13'h0400;
   localparam ST_WR2 = 13'h0800;
   localparam ST_DONE = 13'h1000;

   // ==========================================================
   // Helper functions.
   function is_bcd;
      input [15:0] v;
      begin
         is_bcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) &&
                  (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
      end
   endfunction

   function [13:0] bcd2bin;
      input [15:0] v;
      begin
         bcd2bin = {10'h000, v[15:12]} * 14'h03E8 +
                   {10'h000, v[11:8]} * 14'h0064 +
                   {10'h000, v[7:4]} * 14'h000A + {10'h000, v[3:0]};
      end
   endfunction

   function [31:0] bcd_add;
      input [31:0] a;
      input [15:0] b;
      integer i;
      reg [4:0] s;
      reg c;
      reg [31:0] bb;
      begin
         c = 1'b0;
         bb = {16'h0000, b};
         bcd_add = 32'h00000000;
         for (i = 0; i < 8; i = i + 1) begin
            s = {1'b0, a[4*i +: 4]} + {1'b0, bb[4*i +: 4]} + {4'h0, c};
            c = (s > 5'h09);
            if (c) begin
               s = s + 5'h06;
            end
            bcd_add[4*i +: 4] = s[3:0];
         end
      end
   endfunction

   // ==========================================================
   // Reset release.
   reg rst_s1_q;
   reg rst_sync_n;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_sync_n <= rst_s1_q;
      end
   end

   // ==========================================================
   // State and datapath registers.
   reg [12:0] state_q;
   reg [1:0] op_q;
   reg [15:0] s_op_q;
   reg [15:0] n_op_q;
   reg [15:0] d_op_q;
   reg [8:0] mem_addr_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_mask_q;
   reg [8:0] s_addr_q;
   reg s_bad_q;
   reg [8:0] d_addr_q;
   reg [8:0] base_q;
   reg [9:0] len_q;
   reg [9:0] idx_q;
   reg [31:0] acc_q;
   reg acc_v_q;
   reg bsel_q;
   reg [15:0] p_q;
   reg [6:0] rem_q;
   reg [4:0] div_cnt_q;
   wire [15:0] mem_rd;
   wire idle = (state_q == ST_IDLE);
   wire sum_byte = (op_q == `OP_SUM) && n_op_q[`SUM_BYTE_BIT];
   wire sum_bin = n_op_q[`SUM_BIN_BIT];
   wire sum_sgn = sum_bin && n_op_q[`SUM_SIGNED_BIT];
   wire min_sgn = n_op_q[`MIN_SIGNED_BIT];
   wire run_issue = (idx_q < len_q);
   wire [9:0] run_word = sum_byte ? {1'b0, idx_q[9:1]} : idx_q;

   assign busy = !idle;
   assign irq = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // Combinational decode.
   reg [8:0] mem_a;
   reg mem_we;
   reg [15:0] mem_wd;
   reg [15:0] cur_op;
   reg [13:0] ptr_bin;
   reg [8:0] res_addr;
   reg res_bad;
   reg [13:0] n_bin;
   reg [6:0] avg_n;
   reg n_ok;
   reg [9:0] items;
   reg [9:0] words;
   reg [9:0] rng_lo;
   reg [9:0] rng_hi;
   reg chk_err;
   reg [6:0] slot;
   reg [6:0] slot_nx;
   reg [15:0] item;
   reg [31:0] item_ext;
   reg [31:0] acc_nx;
   reg [7:0] div_t;
   reg [1:0] stat_set;
   reg [1:0] stat_clr;
   always @* begin
      cur_op = (state_q == ST_PD) ? s_op_q : d_op_q;
      ptr_bin = bcd2bin(mem_rd);
      res_addr = cur_op[`IND_BIT] ? ptr_bin[8:0] : cur_op[8:0];
      res_bad = cur_op[`IND_BIT] ?
                (!is_bcd(mem_rd) || ptr_bin >= `MEM_WORDS) :
                (|cur_op[14:9]);
      n_bin = bcd2bin(n_op_q);
      avg_n = (n_op_q >= `AVG_N_SAT_BCD) ? `AVG_N_SAT : n_bin[6:0];
      n_bin = bcd2bin({4'h0, n_op_q[11:0]});
      items = n_bin[9:0];
      words = sum_byte ? (items + 10'h001) >> 1 : items;
      if (op_q == `OP_AVG) begin
         n_ok = is_bcd(n_op_q) && (n_op_q != 16'h0000);
         rng_lo = {1'b0, res_addr};
         rng_hi = {1'b0, res_addr} + {3'h0, avg_n} + 10'h001;
      end else begin
         n_ok = is_bcd({4'h0, n_op_q[11:0]}) && (items != 10'h000);
         rng_lo = {1'b0, s_addr_q};
         rng_hi = {1'b0, s_addr_q} + words - 10'h001;
      end
      chk_err = s_bad_q || res_bad || !n_ok || rng_hi[9] ||
                (rng_hi[8:7] != rng_lo[8:7]) ||
                (op_q == `OP_SUM && res_addr == 9'h1FF);
      slot = (p_q[6:0] < len_q[6:0]) ? p_q[6:0] : 7'h00;
      slot_nx = slot + 7'h01;
      item = mem_rd;
      if (sum_byte) begin
         item = bsel_q ? {8'h00, mem_rd[15:8]} : {8'h00, mem_rd[7:0]};
      end
      item_ext = {16'h0000, item};
      if (sum_sgn) begin
         item_ext = sum_byte ? {{24{item[7]}}, item[7:0]} :
                               {{16{item[15]}}, item};
      end
      acc_nx = acc_q;
      if (op_q == `OP_AVG) begin
         acc_nx = acc_q + {16'h0000, mem_rd};
      end else if (op_q == `OP_SUM) begin
         acc_nx = sum_bin ? acc_q + item_ext : bcd_add(acc_q, item);
      end else if ((mem_rd ^ {min_sgn, 15'h0000}) <
                   (acc_q[15:0] ^ {min_sgn, 15'h0000})) begin
         acc_nx = {16'h0000, mem_rd};
      end
      div_t = {rem_q, acc_q[22]};
      mem_a = mem_addr_q;
      mem_we = idle && wr_en && (addr == `REG_MEM_DATA);
      mem_wd = wr_data;
      case (state_q)
         ST_PS: mem_a = s_op_q[8:0];
         ST_PD: mem_a = d_op_q[8:0];
         ST_A1: mem_a = d_addr_q + 9'h001;
         ST_A2: mem_a = s_addr_q;
         ST_A3: begin
            mem_a = d_addr_q + 9'h002 + {2'h0, slot};
            mem_we = 1'b1;
            mem_wd = mem_rd;
         end
         ST_A4: begin
            mem_a = d_addr_q + 9'h001;
            mem_we = 1'b1;
            mem_wd = p_q;
         end
         ST_RUN: mem_a = base_q + run_word[8:0];
         ST_WR1: begin
            mem_a = d_addr_q;
            mem_we = 1'b1;
            mem_wd = acc_q[15:0];
         end
         ST_WR2: begin
            mem_a = d_addr_q + 9'h001;
            mem_we = 1'b1;
            mem_wd = acc_q[31:16];
         end
         default: mem_a = mem_addr_q;
      endcase
      stat_set = 2'h0;
      stat_set[`IRQ_DONE_BIT] = (state_q == ST_DONE);
      stat_set[`IRQ_ERR_BIT] = (state_q == ST_CHK) && chk_err;
      stat_clr = (wr_en && addr == `REG_IRQ_STAT) ? wr_data[1:0] : 2'h0;
   end

   word_memory u_mem (
      .clk_sys(clk_sys),
      .we(mem_we),
      .addr(mem_a),
      .wdata(mem_wd),
      .rdata(mem_rd)
   );

   // ==========================================================
   // Registers and execution sequence.
   always @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= ST_IDLE;
         op_q <= 2'h0;
         s_op_q <= 16'h0000;
         n_op_q <= 16'h0000;
         d_op_q <= 16'h0000;
         mem_addr_q <= 9'h000;
         irq_stat_q <= 2'h0;
         irq_mask_q <= 2'h0;
         s_addr_q <= 9'h000;
         s_bad_q <= 1'b0;
         d_addr_q <= 9'h000;
         base_q <= 9'h000;
         len_q <= 10'h000;
         idx_q <= 10'h000;
         acc_q <= 32'h00000000;
         acc_v_q <= 1'b0;
         bsel_q <= 1'b0;
         p_q <= 16'h0000;
         rem_q <= 7'h00;
         div_cnt_q <= 5'h00;
         error_flag <= 1'b0;
         equality_flag <= 1'b0;
         rd_data <= 16'h0000;
      end else begin
         irq_stat_q <= (irq_stat_q & ~stat_clr) | stat_set;
         acc_v_q <= 1'b0;
         if (rd_en) begin
            if (addr == `REG_CMD) begin
               rd_data <= {14'h0000, op_q};
            end else if (addr == `REG_STATUS) begin
               rd_data <= {13'h0000, equality_flag, error_flag, busy};
            end else if (addr == `REG_SRC) begin
               rd_data <= s_op_q;
            end else if (addr == `REG_CNT) begin
               rd_data <= n_op_q;
            end else if (addr == `REG_DST) begin
               rd_data <= d_op_q;
            end else if (addr == `REG_MEM_ADDR) begin
               rd_data <= {7'h00, mem_addr_q};
            end else if (addr == `REG_MEM_DATA) begin
               rd_data <= mem_rd;
            end else if (addr == `REG_IRQ_STAT) begin
               rd_data <= {14'h0000, irq_stat_q};
            end else if (addr == `REG_IRQ_MASK) begin
               rd_data <= {14'h0000, irq_mask_q};
            end else begin
               rd_data <= 16'h0000;
            end
         end
         if (wr_en && addr == `REG_IRQ_MASK) begin
            irq_mask_q <= wr_data[1:0];
         end
         if (wr_en && idle) begin
            if (addr == `REG_SRC) begin
               s_op_q <= wr_data;
            end else if (addr == `REG_CNT) begin
               n_op_q <= wr_data;
            end else if (addr == `REG_DST) begin
               d_op_q <= wr_data;
            end else if (addr == `REG_MEM_ADDR) begin
               mem_addr_q <= wr_data[8:0];
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (wr_en && addr == `REG_CMD &&
                   wr_data[`CMD_EXEC_BIT] && wr_data[1:0] != 2'h3) begin
                  op_q <= wr_data[1:0];
                  state_q <= ST_PS;
               end
            end
            ST_PS: state_q <= ST_PD;
            ST_PD: begin
               s_addr_q <= res_addr;
               s_bad_q <= res_bad;
               state_q <= ST_CHK;
            end
            ST_CHK: begin
               d_addr_q <= res_addr;
               error_flag <= chk_err;
               equality_flag <= 1'b0;
               idx_q <= 10'h000;
               base_q <= s_addr_q;
               len_q <= sum_byte ? items : items;
               acc_q <= (op_q == `OP_MIN) ?
                        {16'h0000, ~min_sgn, 15'h7FFF} : 32'h00000000;
               if (chk_err) begin
                  state_q <= ST_DONE;
               end else if (op_q == `OP_AVG) begin
                  len_q <= {3'h0, avg_n};
                  state_q <= ST_A1;
               end else begin
                  state_q <= ST_RUN;
               end
            end
            ST_A1: state_q <= ST_A2;
            ST_A2: begin
               p_q <= mem_rd;
               state_q <= ST_A3;
            end
            ST_A3: begin
               p_q[`HIST_FULL_BIT] <= p_q[`HIST_FULL_BIT] ||
                                      (slot_nx == len_q[6:0]);
               p_q[14:0] <= (slot_nx == len_q[6:0]) ? 15'h0000 :
                            {8'h00, slot_nx};
               state_q <= ST_A4;
            end
            ST_A4: begin
               base_q <= d_addr_q + 9'h002;
               state_q <= p_q[`HIST_FULL_BIT] ? ST_RUN : ST_DONE;
            end
            ST_RUN: begin
               if (run_issue) begin
                  idx_q <= idx_q + 10'h001;
                  bsel_q <= idx_q[0];
                  acc_v_q <= 1'b1;
               end
               if (acc_v_q) begin
                  acc_q <= acc_nx;
               end
               if (!run_issue && !acc_v_q) begin
                  rem_q <= 7'h00;
                  div_cnt_q <= `DIV_STEPS;
                  acc_q <= acc_q + {23'h000000, len_q[9:1]};
                  state_q <= (op_q == `OP_AVG) ? ST_DIV : ST_WR1;
                  if (op_q != `OP_AVG) begin
                     acc_q <= acc_q;
                  end
               end
            end
            ST_DIV: begin
               if (div_t >= {1'b0, len_q[6:0]}) begin
                  rem_q <= div_t[6:0] - len_q[6:0];
                  acc_q <= {9'h000, acc_q[21:0], 1'b1};
               end else begin
                  rem_q <= div_t[6:0];
                  acc_q <= {9'h000, acc_q[21:0], 1'b0};
               end
               div_cnt_q <= div_cnt_q - 5'h01;
               if (div_cnt_q == 5'h01) begin
                  state_q <= ST_WR1;
               end
            end
            ST_WR1: begin
               if (op_q == `OP_MIN) begin
                  equality_flag <= (acc_q[15:0] == 16'h0000);
               end
               state_q <= (op_q == `OP_SUM) ? ST_WR2 : ST_DONE;
            end
            ST_WR2: state_q <= ST_DONE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // average_and_sum_math_unit
`default_nettype wire

/* File: tb/math_unit_props.sv */
// Concurrent checks on the ports of the math unit.
`timescale 1ns/100ps
`default_nettype none
`include "math_unit_consts.vh"
module math_unit_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] rd_data,
   input wire logic irq,
   input wire logic busy,
   input wire logic error_flag,
   input wire logic equality_flag
);
   // Counts the cycles of the current execution, longest sum included.
   logic [10:0] busy_cyc_q = 11'h000;
   always @(posedge clk_sys) begin
      busy_cyc_q <= busy ? busy_cyc_q + 11'h001 : 11'h000;
   end
   // ==========================================================
   // Properties.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   idle_cmd_a: assert property (wr_en && addr == `REG_CMD && !wr_data[4]
      && !busy |=> !busy && $stable(error_flag) && $stable(equality_flag))
      else $error("command without exec bit changed state");
   no_spont_a: assert property (!busy && !(wr_en && addr == `REG_CMD
      && wr_data[4]) |=> !busy) else $error("busy rose without exec");
   exec_start_a: assert property (wr_en && addr == `REG_CMD
      && wr_data[4] && !busy |=> busy) else $error("exec not started");
   busy_bound_a: assert property (busy_cyc_q < 11'h44C)
      else $error("execution did not finish");
   err_hold_a: assert property ($changed(error_flag)
      |-> busy || $past(busy)) else $error("error flag moved while idle");
   eq_hold_a: assert property ($changed(equality_flag)
      |-> busy || $past(busy)) else $error("equality flag moved while idle");
   unmapped_rd_a: assert property (rd_en && addr == 8'hFC
      |=> rd_data == 16'h0000) else $error("unmapped read not zero");
   status_rd_a: assert property (rd_en && addr == `REG_STATUS |=>
      rd_data[2:0] == {$past(equality_flag), $past(error_flag), $past(busy)})
      else $error("status read mismatch");
   reset_quiet_a: assert property ($rose(rst_n) |-> !busy && !irq
      && !error_flag && !equality_flag) else $error("outputs not quiet");
endmodule // math_unit_props
`default_nettype wire

/* File: tb/average_and_sum_math_unit_test.sv */
// Self-checking testbench of the math unit.
`timescale 1ns/100ps
`default_nettype none
`include "math_unit_consts.vh"
module average_and_sum_math_unit_test;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   wire [15:0] rd_data;
   wire irq, busy, error_flag, equality_flag;
   int num_errors = 0;
   int checks_done = 0;
   logic [15:0] v;
   logic [15:0] sc [4] = '{16'h4003, 16'hC003, 16'h0003, 16'h6003};
   logic [15:0] slo [4] = '{16'h3334, 16'h3334, 16'h0000, 16'h01CB};
   logic [15:0] shi [4] = '{16'h0001, 16'hFFFF, 16'h0002, 16'h0000};

   average_and_sum_math_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .irq(irq), .busy(busy), .error_flag(error_flag),
      .equality_flag(equality_flag));

   // ==========================================================
   // Clock and watchdog.
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      end_of_test();
   end

   // ==========================================================
   // Bus tasks and comparison.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask
   task automatic mwr(input logic [15:0] a, input logic [15:0] d);
      wr(`REG_MEM_ADDR, a);
      wr(`REG_MEM_DATA, d);
   endtask
   task automatic chk(input string n, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkm(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] d;
      wr(`REG_MEM_ADDR, a);
      repeat (2) @(posedge clk_sys);
      rd(`REG_MEM_DATA, d);
      chk($sformatf("word %h", a), e, d);
   endtask
   task automatic run(input logic [1:0] op, input logic [15:0] s, c, d);
      int n;
      n = 0;
      wr(`REG_SRC, s);
      wr(`REG_CNT, c);
      wr(`REG_DST, d);
      wr(`REG_CMD, {11'h000, 1'b1, 2'h0, op});
      @(posedge clk_sys);
      #1;
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 2000) num_errors++;
   endtask
   task automatic flag(input logic e, q);
      chk("error flag", {15'h0000, e}, {15'h0000, error_flag});
      chk("equality flag", {15'h0000, q}, {15'h0000, equality_flag});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Tests.
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(`REG_STATUS, v);
      chk("status", 16'h0000, v);
      rd(8'hFC, v);
      chk("unmapped", 16'h0000, v);
      $display("test reset done");
      mwr(16'h0011, 16'h0000);
      mwr(16'h0010, 16'h1234);
      mwr(16'h0013, 16'h5555);
      mwr(16'h0008, 16'h000A);
      run(`OP_AVG, 16'h0008, 16'h0002, 16'h0010);
      chkm(16'h0012, 16'h000A);
      chkm(16'h0010, 16'h1234);
      wr(`REG_CMD, 16'h0000);
      repeat (20) @(posedge clk_sys);
      chkm(16'h0013, 16'h5555);
      mwr(16'h0008, 16'h000B);
      run(`OP_AVG, 16'h0008, 16'h0002, 16'h0010);
      chkm(16'h0013, 16'h000B);
      chkm(16'h0010, 16'h000B);
      flag(1'b0, 1'b0);
      $display("test average done");
      mwr(16'h0081, 16'h0000);
      mwr(16'h0080, 16'hFFFF);
      for (int i = 0; i < 64; i++) begin
         mwr(16'h0007, 16'(i));
         run(`OP_AVG, 16'h0007, 16'h0099, 16'h0080);
         if (i == 62) chkm(16'h0080, 16'hFFFF);
      end
      chkm(16'h00C1, 16'h003F);
      chkm(16'h0080, 16'h0020);
      $display("test saturation done");
      wr(`REG_IRQ_MASK, 16'h0002);
      mwr(16'h0080, 16'h0000);
      run(`OP_AVG, 16'h0007, 16'h0002, 16'h007F);
      flag(1'b1, 1'b0);
      chk("irq", 16'h0001, {15'h0000, irq});
      rd(`REG_IRQ_STAT, v);
      chk("irq status", 16'h0003, v);
      wr(`REG_IRQ_STAT, 16'h0003);
      #1;
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      mwr(16'h0021, 16'h0000);
      run(`OP_AVG, 16'h0007, 16'h001A, 16'h0020);
      flag(1'b1, 1'b0);
      mwr(16'h0005, 16'h00AB);
      run(`OP_AVG, 16'h0007, 16'h0002, 16'h8005);
      flag(1'b1, 1'b0);
      wr(`REG_IRQ_MASK, 16'h0000);
      wr(`REG_IRQ_STAT, 16'h0003);
      run(`OP_AVG, 16'h0007, 16'h001A, 16'h0020);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      $display("test errors done");
      mwr(16'h0100, 16'h9999);
      mwr(16'h0101, 16'h9999);
      mwr(16'h0102, 16'h0002);
      for (int i = 0; i < 4; i++) begin
         run(`OP_SUM, 16'h0100, sc[i], 16'h0140);
         chkm(16'h0140, slo[i]);
         chkm(16'h0141, shi[i]);
         flag(1'b0, 1'b0);
      end
      $display("test sum done");
      mwr(16'h0100, 16'h0005);
      mwr(16'h0101, 16'h0000);
      mwr(16'h0102, 16'h0007);
      run(`OP_MIN, 16'h0100, 16'h0003, 16'h0150);
      flag(1'b0, 1'b1);
      mwr(16'h0101, 16'h0003);
      run(`OP_MIN, 16'h0100, 16'h0003, 16'h0150);
      flag(1'b0, 1'b0);
      $display("test minimum done");
      end_of_test();
   end
endmodule // average_and_sum_math_unit_test

bind average_and_sum_math_unit math_unit_props props_u (.clk_sys(clk_sys),
   .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .busy(busy),
   .error_flag(error_flag), .equality_flag(equality_flag));
`default_nettype wire
